// ==== hdl/pwm_channel.sv ====
/*
  One pulse width modulation channel with APB registers, double
  buffered period and width, a 16-bit period counter and one output pin.
  Assumes an APB master on ref_clk and a load that samples pwm_pin.
  // Notes on behaviour
  // (R1) Disabled: pin constant at polarity level
  // (R2) Polarity one inverts the whole waveform
  // (R3) Disabled: prescaler reset, comparators inactive
  // (R4) Disabled: counter stopped at one
  // (R5) Disabled: user registers copied into buffers
  // (R6) Enable rise: pulse, count from one, flag
  // (R7) Enabled: waveform from buffers, refresh per period
  // (R8) Software: zero width period before disabling
  // (R9) Eight rates, alternate ratio, changeable anytime
  // (R10) Period buffer loads at period end or reload
  // (R11) Width buffer loads at period end or reload
  // (R12) Disabled: write reaches buffer without delay
  // (R13) User registers untouched; buffers hidden
  // (R14) Counter read only, one at reset/disabled
  // (R15) Flag sticky on completion, clear while disabled
  // (R16) Flag cleared by read one, write zero
  // (R17) Reload: copy, counter one, flag, pulse
  // (R18) Flag set raises request at irq level
  // (R19) Width match clears; period match restarts
*/
`timescale 1ns/1ps
`default_nettype none

module pwm_channel
(
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        prescale_ratio_select,
  output logic             pwm_pin,
  output logic             irq_request,
  output logic [2:0]       irq_level_out,
  output logic             irq
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [15:0]                  period_next_reg;
  logic [15:0]                  width_next_reg;
  logic [15:0]                  period_buf_q;
  logic [15:0]                  width_buf_q;
  logic [15:0]                  period_counter;
  logic                         period_done_flag;
  logic                         flag_read_armed;
  logic [2:0]                   irq_level;
  logic                         arb_bit;
  logic                         output_polarity;
  logic                         enable;
  logic                         enable_q;
  logic [2:0]                   counter_rate_select;
  logic                         out_ff;
  logic [pwm_pkg::IRQ_BITS-1:0] irq_status;
  logic [pwm_pkg::IRQ_BITS-1:0] irq_mask;
  logic                         count_tick;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire access   = psel && penable;
  wire wr       = access && pwrite;
  wire rd       = access && !pwrite;
  wire sel_sc   = (paddr == pwm_pkg::OFS_STATUS_CONTROL);
  wire sel_per  = (paddr == pwm_pkg::OFS_PERIOD_VALUE);
  wire sel_wid  = (paddr == pwm_pkg::OFS_WIDTH_VALUE);
  wire sel_cnt  = (paddr == pwm_pkg::OFS_RUNNING_COUNT);
  wire sel_ist  = (paddr == pwm_pkg::OFS_IRQ_STATUS);
  wire sel_imk  = (paddr == pwm_pkg::OFS_IRQ_MASK);
  wire mapped   = sel_sc || sel_per || sel_wid || sel_cnt || sel_ist || sel_imk;
  wire wr_sc    = wr && sel_sc;
  wire wr_per   = wr && sel_per;
  wire wr_wid   = wr && sel_wid;
  wire wr_ist   = wr && sel_ist;
  wire wr_imk   = wr && sel_imk;

  assign pready  = 1'b1;
  assign pslverr = access && !mapped;

  // ----------------------------------------------------------------
  // Channel control decode
  // ----------------------------------------------------------------
  wire enable_rise = enable && !enable_q;
  // Reload while disabled does nothing: the buffers already track
  wire reload      = wr_sc && pwdata[pwm_pkg::BIT_RELOAD] && enable; // [R17]
  // Disabled: buffers follow the user registers in the same cycle
  wire [15:0] period_active_buf = enable ? period_buf_q : period_next_reg; // [R5] [R12]
  wire [15:0] width_active_buf  = enable ? width_buf_q : width_next_reg; // [R5] [R12]
  // Comparators only act on a counter tick while enabled
  wire period_match = enable && count_tick
                      && (period_counter == period_active_buf); // [R3] [R19]
  wire width_match  = enable && count_tick
                      && (period_counter == width_active_buf); // [R3] [R19]
  wire period_end   = period_match || reload; // [R10] [R11]
  wire width_nz     = (width_next_reg != pwm_pkg::NEXT_RESET);
  wire flag_set     = enable && (enable_rise || period_end); // [R6] [R15] [R17]
  wire flag_clear   = wr_sc && !pwdata[pwm_pkg::BIT_FLAG] && flag_read_armed; // [R16]
  wire pulse_start  = enable && (enable_rise || (period_end && width_nz));
  wire next_pin     = out_ff ^ output_polarity; // [R1] [R2]

  wire [15:0] sc_read = {period_done_flag, irq_level, arb_bit, 3'h0, pwm_pin, 2'h0,
                         output_polarity, enable, counter_rate_select};

  // ----------------------------------------------------------------
  // Read data, registered in the setup cycle
  // ----------------------------------------------------------------
  wire [31:0] next_prdata =
      sel_sc  ? {16'h0000, sc_read} :
      sel_per ? {16'h0000, period_next_reg} :
      sel_wid ? {16'h0000, width_next_reg} :
      sel_cnt ? {16'h0000, period_counter} : // [R14]
      sel_ist ? {30'h0000_0000, irq_status} :
      sel_imk ? {30'h0000_0000, irq_mask} : 32'h0000_0000;

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      prdata <= 32'h0000_0000;
    else if (psel && !penable)
      prdata <= next_prdata;
  end

  // ----------------------------------------------------------------
  // Control and user registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      irq_level           <= 3'h0;
      arb_bit             <= 1'b0;
      output_polarity     <= 1'b0;
      enable              <= 1'b0;
      counter_rate_select <= 3'h0;
    end
    else if (wr_sc)
    begin
      irq_level           <= pwdata[pwm_pkg::POS_IRQ_LEVEL +: 3];
      arb_bit             <= pwdata[pwm_pkg::BIT_ARB3];
      output_polarity     <= pwdata[pwm_pkg::BIT_POLARITY];
      enable              <= pwdata[pwm_pkg::BIT_ENABLE];
      counter_rate_select <= pwdata[pwm_pkg::POS_RATE +: 3]; // [R9]
    end
  end

  // Only software writes these; hardware never modifies them
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      period_next_reg <= pwm_pkg::NEXT_RESET;
      width_next_reg  <= pwm_pkg::NEXT_RESET;
    end
    else
    begin
      if (wr_per)
        period_next_reg <= pwdata[15:0]; // [R13]
      if (wr_wid)
        width_next_reg <= pwdata[15:0]; // [R13]
    end
  end

  // ----------------------------------------------------------------
  // Active buffers, hidden from the bus
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      period_buf_q <= pwm_pkg::NEXT_RESET;
      width_buf_q  <= pwm_pkg::NEXT_RESET;
    end
    else if (!enable || period_end)
    begin
      period_buf_q <= period_next_reg; // [R5] [R7] [R10]
      width_buf_q  <= width_next_reg; // [R5] [R7] [R11]
    end
  end

  // ----------------------------------------------------------------
  // Period counter
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      period_counter <= pwm_pkg::COUNTER_START; // [R14]
    else if (!enable || enable_rise || period_end)
      period_counter <= pwm_pkg::COUNTER_START; // [R4] [R6] [R17] [R19]
    else if (count_tick)
      period_counter <= 16'(period_counter + 16'h0001); // [R7]
  end

  // ----------------------------------------------------------------
  // Output flip-flop and pin
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      out_ff <= 1'b0;
    else if (!enable)
      out_ff <= 1'b0; // [R1]
    else if (enable_rise)
      out_ff <= 1'b1; // [R6]
    else if (period_end)
      out_ff <= width_nz; // [R17] [R19]
    else if (width_match)
      out_ff <= 1'b0; // [R19]
  end

  // Registered so the pin never glitches on a polarity write
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pwm_pin  <= 1'b0;
      enable_q <= 1'b0;
    end
    else
    begin
      pwm_pin  <= next_pin; // [R1] [R2]
      enable_q <= enable;
    end
  end

  // ----------------------------------------------------------------
  // Period done flag: set wins over clear
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      period_done_flag <= 1'b0;
      flag_read_armed  <= 1'b0;
    end
    else
    begin
      if (!enable)
        period_done_flag <= 1'b0; // [R15]
      else if (flag_set)
        period_done_flag <= 1'b1; // [R15]
      else if (flag_clear)
        period_done_flag <= 1'b0; // [R16]
      if (rd && sel_sc && period_done_flag)
        flag_read_armed <= 1'b1; // [R16]
      else if (wr_sc || !period_done_flag)
        flag_read_armed <= 1'b0;
    end
  end

  assign irq_request   = period_done_flag && (irq_level != 3'h0); // [R18]
  assign irq_level_out = irq_level; // [R18]

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  wire [pwm_pkg::IRQ_BITS-1:0] irq_events = {pulse_start, flag_set};
  wire [pwm_pkg::IRQ_BITS-1:0] irq_w1c    = wr_ist ? pwdata[pwm_pkg::IRQ_BITS-1:0]
                                                   : '0;

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      irq_status <= '0;
      irq_mask   <= '0;
    end
    else
    begin
      irq_status <= (irq_status & ~irq_w1c) | irq_events;
      if (wr_imk)
        irq_mask <= pwdata[pwm_pkg::IRQ_BITS-1:0];
    end
  end

  assign irq = |(irq_status & irq_mask);

  // ----------------------------------------------------------------
  // Counter clock
  // ----------------------------------------------------------------
  pwm_prescaler i_pwm_prescaler
  (
    .ref_clk     (ref_clk),
    .sys_rst     (sys_rst),
    .run         (enable && !enable_rise), // [R3] [R6]
    .ratio_alt   (prescale_ratio_select),
    .rate_select (counter_rate_select),
    .count_tick  (count_tick)
  );

endmodule

`default_nettype wire

// ==== hdl/pwm_pkg.sv ====
/*
  Shared constants for the pulse modulator channel: register offsets,
  field positions, reset values and the counter clock rate codes.
  Assumes a 32-bit APB register bus, one aligned word per register.
*/
`default_nettype none

package pwm_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_STATUS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_PERIOD_VALUE   = 8'h04;
  localparam logic [7:0] OFS_WIDTH_VALUE    = 8'h08;
  localparam logic [7:0] OFS_RUNNING_COUNT  = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STATUS     = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK       = 8'h14;

  // ----------------------------------------------------------------
  // status_control_reg fields
  // ----------------------------------------------------------------
  localparam int BIT_FLAG      = 15;
  localparam int POS_IRQ_LEVEL = 12;
  localparam int BIT_ARB3      = 11;
  localparam int BIT_PIN       = 7;
  localparam int BIT_RELOAD    = 5;
  localparam int BIT_POLARITY  = 4;
  localparam int BIT_ENABLE    = 3;
  localparam int POS_RATE      = 0;

  // ----------------------------------------------------------------
  // Interrupt status / mask bits
  // ----------------------------------------------------------------
  localparam int IRQ_PERIOD_DONE = 0;
  localparam int IRQ_PULSE_START = 1;
  localparam int IRQ_BITS        = 2;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [15:0] COUNTER_START   = 16'h0001;
  localparam logic [15:0] NEXT_RESET      = 16'h0000;
  localparam logic [2:0]  RATE_SLOWEST    = 3'h7;
  localparam logic [7:0]  MASK_SLOWEST    = 8'hFF;
  localparam logic [1:0]  BASE_DIV_NORMAL = 2'h1;
  localparam logic [1:0]  BASE_DIV_ALT    = 2'h2;

endpackage

`default_nettype wire

// ==== hdl/pwm_prescaler.sv ====
/*
  Counter clock prescaler: a divide-by-2 or divide-by-3 base stage and
  an 8-bit divide stage with eight selectable taps.
  Assumes rate and ratio select are on the ref_clk domain.
*/
`timescale 1ns/1ps
`default_nettype none

module pwm_prescaler
(
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic       run,
  input  wire logic       ratio_alt,
  input  wire logic [2:0] rate_select,
  output logic            count_tick
);

  logic [1:0] base_cnt;
  logic [7:0] div_cnt;
  wire  [1:0] base_top  = ratio_alt ? pwm_pkg::BASE_DIV_ALT : pwm_pkg::BASE_DIV_NORMAL;
  wire        base_tick = run && (base_cnt >= base_top);
  wire  [7:0] tap_mask  = (rate_select == pwm_pkg::RATE_SLOWEST) ? pwm_pkg::MASK_SLOWEST
                        : 8'((9'h001 << rate_select) - 9'h001);

  // ----------------------------------------------------------------
  // Divider chain, held cleared while the channel is off
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      base_cnt <= 2'h0;
      div_cnt  <= 8'h00;
    end
    else if (!run)
    begin
      base_cnt <= 2'h0; // [R3]
      div_cnt  <= 8'h00; // [R3]
    end
    else
    begin
      base_cnt <= base_tick ? 2'h0 : 2'(base_cnt + 2'h1);
      if (base_tick)
        div_cnt <= 8'(div_cnt + 8'h01);
    end
  end

  // Code may change at any time; a change only moves the next tap hit
  assign count_tick = base_tick && ((div_cnt & tap_mask) == tap_mask); // [R9]

endmodule

`default_nettype wire

// ==== verif/pwm_channel_assertions.sv ====
/*
  Port checker for pwm_channel.
  Assumes it is bound to pwm_channel and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module pwm_channel_assertions
(
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        prescale_ratio_select,
  input wire logic        pwm_pin,
  input wire logic        irq_request,
  input wire logic [2:0]  irq_level_out,
  input wire logic        irq
);
  // ------
  // Shadow of enable and polarity
  // ------
  logic       en_q;
  logic       pol_q;
  logic [1:0] dis_cnt;
  wire        acc    = psel && penable;
  wire        wr_sc  = acc && pwrite && (paddr == pwm_pkg::OFS_STATUS_CONTROL);
  wire        rd_sc  = acc && !pwrite && (paddr == pwm_pkg::OFS_STATUS_CONTROL);
  wire        rd_cnt = acc && !pwrite && (paddr == pwm_pkg::OFS_RUNNING_COUNT);
  wire        idle   = (dis_cnt == 2'h3);

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      en_q  <= 1'b0;
      pol_q <= 1'b0;
    end
    else if (wr_sc)
    begin
      en_q  <= pwdata[pwm_pkg::BIT_ENABLE];
      pol_q <= pwdata[pwm_pkg::BIT_POLARITY];
    end
  end

  // Pin is registered, so give it time to settle after any control write
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      dis_cnt <= 2'h0;
    else if (en_q || wr_sc)
      dis_cnt <= 2'h0;
    else if (!idle)
      dis_cnt <= dis_cnt + 2'h1;
  end

  // ------
  // Properties
  // ------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  a_disabled_pin_level: assert property (idle |-> pwm_pin == pol_q)
    else $error("pin not at polarity level while disabled");
  a_enable_first_pulse: assert property ($rose(en_q) |-> ##2 pwm_pin != pol_q)
    else $error("no first pulse after enable");
  a_enable_sets_flag: assert property ($rose(en_q) |-> ##1 irq_request == (irq_level_out != 3'h0))
    else $error("flag request missing after enable");
  a_idle_no_request: assert property (idle |-> !irq_request)
    else $error("request while disabled");
  a_idle_count_one: assert property (idle && rd_cnt |-> prdata == {16'h0000, pwm_pkg::COUNTER_START})
    else $error("counter not one while disabled");
  a_reload_reads_zero: assert property (rd_sc |-> !prdata[pwm_pkg::BIT_RELOAD])
    else $error("reload bit reads one");
  a_level_field: assert property (wr_sc |=> irq_level_out == $past(pwdata[14:12]))
    else $error("level output not the written field");
  a_level_gates_req: assert property (irq_level_out == 3'h0 |-> !irq_request)
    else $error("request with zero level");
endmodule
`default_nettype wire

bind pwm_channel pwm_channel_assertions i_pwm_channel_assertions (.ref_clk(ref_clk),
  .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .prescale_ratio_select(prescale_ratio_select), .pwm_pin(pwm_pin),
  .irq_request(irq_request), .irq_level_out(irq_level_out), .irq(irq));

// ==== verif/pwm_load_model.sv ====
/*
  Load on the pin: counts high samples and rising edges.
  Assumes the pin is sampled on ref_clk; clear restarts both counts.
*/
`timescale 1ns/1ps
`default_nettype none
module pwm_load_model
(
  input  wire logic   ref_clk,
  input  wire logic   level,
  input  wire logic   clear,
  output logic [31:0] high_cycles,
  output logic [31:0] rises
);
  logic last;

  always_ff @(posedge ref_clk)
  begin
    last <= level;
    if (clear)
    begin
      high_cycles <= 32'h0;
      rises       <= 32'h0;
    end
    else
    begin
      high_cycles <= high_cycles + {31'h0, level};
      rises       <= rises + {31'h0, level && !last};
    end
  end
endmodule
`default_nettype wire

// ==== verif/pwm_channel_bench.sv ====
/*
  Bench for pwm_channel: APB tasks, waveform and register scenarios.
  Assumes pwm_load_model watches the pin.
*/
`timescale 1ns/1ps
`default_nettype none
module pwm_channel_bench;
  logic        ref_clk, sys_rst, psel, penable, pwrite, ratio, clr, err;
  logic        pready, pslverr, pwm_pin, irq_request, irq;
  logic [2:0]  irq_level_out;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, high_cycles, rises;
  int          mismatches = 0;
  int          samples_checked = 0;

  pwm_channel i_pwm_channel (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .prescale_ratio_select(ratio), .pwm_pin(pwm_pin),
    .irq_request(irq_request), .irq_level_out(irq_level_out), .irq(irq));
  pwm_load_model i_pwm_load_model (.ref_clk(ref_clk), .level(pwm_pin), .clear(clr),
    .high_cycles(high_cycles), .rises(rises));

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ------
  // Shared tasks
  // ------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do
    begin
      @(posedge ref_clk);
    end
    while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  // Window must span whole periods so the counts do not depend on phase
  task observe(input int win, input logic [31:0] exp_high, input logic [31:0] exp_rises);
    @(posedge ref_clk);
    clr <= 1'b1;
    @(posedge ref_clk);
    clr <= 1'b0;
    repeat (win) @(posedge ref_clk);
    #1;
    check(high_cycles, exp_high);
    check(rises, exp_rises);
  endtask

  // ------
  // Scenarios
  // ------
  task t_regs;
    rdchk(pwm_pkg::OFS_STATUS_CONTROL, 32'h0000_0000);
    apb(1'b1, pwm_pkg::OFS_RUNNING_COUNT, 32'h0000_1234);
    rdchk(pwm_pkg::OFS_RUNNING_COUNT, 32'h0000_0001);
    apb(1'b0, 8'h18, 32'h0);
    check({rd[30:0], err}, 32'h0000_0001);
  endtask

  task t_rates;
    int div;
    for (int alt = 0; alt < 2; alt++)
      for (int code = 0; code < 8; code++)
      begin
        div = (code == 7) ? (alt ? 768 : 512) : ((alt ? 3 : 2) << code);
        ratio <= alt[0];
        apb(1'b1, pwm_pkg::OFS_PERIOD_VALUE, 32'h0000_0002);
        apb(1'b1, pwm_pkg::OFS_WIDTH_VALUE, 32'h0000_0001);
        apb(1'b1, pwm_pkg::OFS_STATUS_CONTROL, 32'h0000_0008 + 32'(code));
        repeat (4 * div) @(posedge ref_clk);
        observe(4 * div, 32'(2 * div), 32'h0000_0002);
        apb(1'b1, pwm_pkg::OFS_STATUS_CONTROL, 32'h0000_0000);
      end
  endtask

  // Inverted polarity turns the high pulse into a low pulse
  task t_polarity;
    ratio <= 1'b0;
    apb(1'b1, pwm_pkg::OFS_PERIOD_VALUE, 32'h0000_0004);
    apb(1'b1, pwm_pkg::OFS_WIDTH_VALUE, 32'h0000_0001);
    apb(1'b1, pwm_pkg::OFS_STATUS_CONTROL, 32'h0000_0018);
    repeat (16) @(posedge ref_clk);
    observe(16, 32'h0000_000C, 32'h0000_0002);
    apb(1'b1, pwm_pkg::OFS_STATUS_CONTROL, 32'h0000_0000);
  endtask

  task t_zero_width;
    ratio <= 1'b0;
    apb(1'b1, pwm_pkg::OFS_PERIOD_VALUE, 32'h0000_0004);
    apb(1'b1, pwm_pkg::OFS_STATUS_CONTROL, 32'h0000_0008);
    repeat (16) @(posedge ref_clk);
    apb(1'b1, pwm_pkg::OFS_WIDTH_VALUE, 32'h0000_0000);
    repeat (16) @(posedge ref_clk);
    observe(16, 32'h0, 32'h0);
    apb(1'b1, pwm_pkg::OFS_STATUS_CONTROL, 32'h0000_0010);
    repeat (4) @(posedge ref_clk);
    check({31'h0, pwm_pin}, 32'h0000_0001);
    rdchk(pwm_pkg::OFS_STATUS_CONTROL, 32'h0000_0090);
  endtask

  task t_flags;
    apb(1'b1, pwm_pkg::OFS_IRQ_MASK, 32'h0000_0001);
    apb(1'b1, pwm_pkg::OFS_PERIOD_VALUE, 32'h0000_FFFF);
    apb(1'b1, pwm_pkg::OFS_WIDTH_VALUE, 32'h0000_8000);
    apb(1'b1, pwm_pkg::OFS_STATUS_CONTROL, 32'h0000_300F);
    repeat (3) @(posedge ref_clk);
    check({30'h0, irq_request, irq}, 32'h0000_0003);
    rdchk(pwm_pkg::OFS_STATUS_CONTROL, 32'h0000_B08F);
    apb(1'b1, pwm_pkg::OFS_STATUS_CONTROL, 32'h0000_308F);
    rdchk(pwm_pkg::OFS_STATUS_CONTROL, 32'h0000_308F);
    apb(1'b1, pwm_pkg::OFS_STATUS_CONTROL, 32'h0000_B08F);
    rdchk(pwm_pkg::OFS_STATUS_CONTROL, 32'h0000_308F);
    apb(1'b1, pwm_pkg::OFS_IRQ_STATUS, 32'h0000_0001);
    rdchk(pwm_pkg::OFS_IRQ_STATUS, 32'h0000_0002);
    rdchk(pwm_pkg::OFS_PERIOD_VALUE, 32'h0000_FFFF);
    check({30'h0, irq_request, irq}, 32'h0000_0000);
    apb(1'b1, pwm_pkg::OFS_STATUS_CONTROL, 32'h0000_30AF);
    rdchk(pwm_pkg::OFS_STATUS_CONTROL, 32'h0000_B08F);
    check({31'h0, irq}, 32'h0000_0001);
    apb(1'b1, pwm_pkg::OFS_IRQ_MASK, 32'h0000_0000);
    rdchk(pwm_pkg::OFS_WIDTH_VALUE, 32'h0000_8000);
    check({31'h0, irq}, 32'h0000_0000);
    apb(1'b1, pwm_pkg::OFS_STATUS_CONTROL, 32'h0000_3000);
    repeat (3) @(posedge ref_clk);
    rdchk(pwm_pkg::OFS_STATUS_CONTROL, 32'h0000_3000);
    rdchk(pwm_pkg::OFS_RUNNING_COUNT, 32'h0000_0001);
  endtask

  task results;
    $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Whole run is about 16k cycles; this bound leaves ample slack
  initial
  begin
    #500000;
    mismatches++;
    results();
  end

  initial
  begin
    sys_rst = 1'b1;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    ratio   = 1'b0;
    clr     = 1'b0;
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_regs();
    t_rates();
    t_polarity();
    t_zero_width();
    t_flags();
    results();
  end
endmodule
`default_nettype wire
